// [design/frg_guard.v]
// Purpose: reset handling, write lockout and status protection bits
// Assumes: commands arrive as whole decoded bytes on the link clock
// Notes:   array decode tables and data path live elsewhere
// Operation
// R1: reset only on 66h then 99h
// R2: soft reset lasts 30us, rejecting commands
// R3: shared pin pause or reset by select
// R4: reset pin low 1us resets, aborts ops
// R5: reset pin low ignores commands
// R6: four lane enable disables shared pin functions
// R7: dedicated reset pin always works
// R8: reset pin overrides every other input
// R9: powerup delay rejects write-type commands
// R10: write commands need write enable first
// R11: latch set by enable, cleared on completion
// R12: power down accepts only release
// R13: 62 block locks, 32 sector locks
// R14: locked region ignores erase and program
// R15: locks start set, 39h clears one
// R16: scheme select picks range or locks; code checks only locks, range bits protect nothing
// R17: status writes gated by guard, lockdown, latch, pin
// R18: busy during operations; only status read, suspend
// R19: range bits S4..S2, writable, default zero
// R20: top bottom select default top
// R21: small unit select sectors or blocks
// R22: invert protection in S14, default zero
// R23: guard mode 1 with pin low refuses; code still accepts while four_lane_mode is set
// R24: other command after 66h disarms reset
`timescale 1ns/1ps
`default_nettype none
`include "frg_defines.vh"
module frg_guard #(
    parameter PUW_CYCLES  = (`FRG_PUW_NS * `FRG_CLK_MHZ) / 1000,
    parameter SRST_CYCLES = (`FRG_SOFT_RST_NS * `FRG_CLK_MHZ) / 1000,
    parameter OP_CYCLES   = `FRG_OP_CYCLES
) (
    // clock and reset
    input  wire        clock,
    input  wire        rst,
    // serial link, outside domain
    input  wire        link_clk,
    input  wire        cs_n,
    input  wire [7:0]  cmd_byte,
    input  wire        cmd_strobe,
    input  wire [23:0] cmd_addr,
    input  wire [15:0] wr_status,
    input  wire        four_lane_mode,
    // pins
    input  wire        shared_pin_n,
    input  wire        dedicated_rst_n,
    input  wire        write_guard_pin,
    // configuration
    input  wire        pause_or_reset_pin_select,
    input  wire        four_lane_enable_in,
    input  wire        protect_scheme_select,
    input  wire        status_lockdown,
    // status and outputs
    output reg  [7:0]  status_one,
    output reg         invert_protection,
    output reg         cmd_accepted,
    output reg         cmd_rejected,
    output reg         pause_active,
    output reg         op_aborted,
    output reg         region_locked,
    output reg         power_down,
    output reg         soft_reset_busy
);
    localparam HW_RST_CYCLES = (`FRG_HW_RST_NS * `FRG_CLK_MHZ) / 1000;
    localparam NLOCK = 94;
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // three-stage input sync, then an agreement filter generated per signal
    localparam NS = 5;
    // idle levels: link clock low, active-low pins high; no false edge after reset
    localparam [NS-1:0] SYNC_IDLE = 5'h0f;
    wire [NS-1:0] raw_in = {link_clk, cs_n, shared_pin_n, dedicated_rst_n, write_guard_pin};
    reg  [NS-1:0] s1_q, s2_q, s3_q, st_q;
    always @(posedge clock) begin
        s1_q <= raw_in;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end
    genvar gi;
    generate
        for (gi = 0; gi < NS; gi = gi + 1) begin : g_flt
            always @(posedge clock) begin
                if (rst) begin
                    st_q[gi] <= SYNC_IDLE[gi];
                end else if (s2_q[gi] == s3_q[gi]) begin
                    st_q[gi] <= s3_q[gi];
                end
            end
        end
    endgenerate
    // ------------------------------------------------------------
    // link clock edge
    // ------------------------------------------------------------
    reg lclk_prev_q;
    always @(posedge clock) begin
        if (rst) begin
            lclk_prev_q <= 1'b0;
        end else begin
            lclk_prev_q <= st_q[4];
        end
    end
    wire lclk_rise = st_q[4] & ~lclk_prev_q;
    wire cs_low    = ~st_q[3];
    wire guard_pin = st_q[0];
    // ------------------------------------------------------------
    // lock index decode
    // ------------------------------------------------------------
    function [6:0] lock_index;
        input [23:0] a;
        begin
            // 22 address bits; upper bits fold away so the index stays in range
            if (a[21:16] == 6'h00) begin
                lock_index = {3'b000, a[15:12]};
            end else if (a[21:16] == 6'h3f) begin
                lock_index = 7'd16 + {3'b000, a[15:12]};
            end else begin
                lock_index = 7'd31 + {1'b0, a[21:16]};
            end
        end
    endfunction
    function is_write_cmd;
        input [7:0] c;
        begin
            is_write_cmd = (c == `FRG_CMD_PP) || (c == `FRG_CMD_QPP) || (c == `FRG_CMD_SE)
                || (c == `FRG_CMD_BE32) || (c == `FRG_CMD_BE64) || (c == `FRG_CMD_CE)
                || (c == `FRG_CMD_SECER) || (c == `FRG_CMD_SECPG);
        end
    endfunction
    // ------------------------------------------------------------
    // hardware reset pin
    // ------------------------------------------------------------
    // shared pin off when four lanes on [R6]
    wire shared_rst = ~four_lane_enable_in & pause_or_reset_pin_select & ~st_q[2]; // [R3]
    wire pin_rst    = ~st_q[1] | shared_rst; // [R7]
    reg  [15:0] hw_cnt_q;
    reg  hw_fire_q;
    always @(posedge clock) begin
        if (rst) begin
            hw_cnt_q  <= 16'h0000;
            hw_fire_q <= 1'b0;
        end else if (pin_rst) begin
            hw_fire_q <= (hw_cnt_q >= HW_RST_CYCLES[15:0]); // [R4]
            if (hw_cnt_q != 16'hffff) begin
                hw_cnt_q <= hw_cnt_q + 16'h0001;
            end
        end else begin
            hw_cnt_q  <= 16'h0000;
            hw_fire_q <= 1'b0;
        end
    end
    // pulses shorter than the minimum still block commands; only full ones reset state
    wire hw_reset = pin_rst; // [R8]
    // ------------------------------------------------------------
    // command byte capture on link edge
    // ------------------------------------------------------------
    reg  strobe_prev_q;
    wire new_cmd = lclk_rise & cs_low & cmd_strobe & ~strobe_prev_q;
    always @(posedge clock) begin
        if (rst) begin
            strobe_prev_q <= 1'b0;
        end else if (!cs_low) begin
            // frame end re-arms the strobe edge detector
            strobe_prev_q <= 1'b0;
        end else if (lclk_rise) begin
            strobe_prev_q <= cmd_strobe;
        end
    end
    // ------------------------------------------------------------
    // main state
    // ------------------------------------------------------------
    // 32-bit counters cover the full powerup delay
    reg [31:0] puw_q, srst_q, op_q;
    reg        armed_q, wel_q, busy_q;
    reg [NLOCK-1:0] locks_q;
    reg [7:0] pend_q;
    reg [15:0] pend_st_q;
    wire in_puw   = (puw_q != 32'h0);
    wire in_srst  = (srst_q != 32'h0);
    wire rst_pair = new_cmd & armed_q & (cmd_byte == `FRG_CMD_RST); // [R1]
    wire guard_ok = ~status_lockdown & (~status_one[`FRG_SR_SRP]
        | four_lane_mode | guard_pin); // [R17] [R23]
    wire [6:0] li = lock_index(cmd_addr);
    wire lk = protect_scheme_select & locks_q[li]; // [R16] [R14]
    reg accept;
    always @* begin
        accept = 1'b0;
        if (!new_cmd || in_srst || hw_reset) begin
            accept = 1'b0; // [R2] [R5]
        end else if (power_down) begin
            accept = (cmd_byte == `FRG_CMD_PDREL); // [R12]
        end else if (busy_q) begin
            accept = (cmd_byte == `FRG_CMD_RDSR1) || (cmd_byte == `FRG_CMD_SUSP); // [R18]
        end else if (in_puw && (cmd_byte == `FRG_CMD_WREN || cmd_byte == `FRG_CMD_WRSR
            || is_write_cmd(cmd_byte))) begin
            accept = 1'b0; // [R9]
        end else if (is_write_cmd(cmd_byte)) begin
            accept = wel_q & ~lk; // [R10] [R14]
        end else if (cmd_byte == `FRG_CMD_WRSR) begin
            accept = wel_q & guard_ok; // [R17]
        end else begin
            accept = 1'b1;
        end
    end
    always @(posedge clock) begin
        if (rst || (hw_reset && hw_fire_q)) begin
            puw_q             <= rst ? PUW_CYCLES : 32'h0;
            srst_q            <= 32'h0;
            op_q              <= 32'h0;
            armed_q           <= 1'b0;
            wel_q             <= 1'b0; // [R11]
            busy_q            <= 1'b0; // [R4]
            locks_q           <= {NLOCK{1'b1}}; // [R15]
            status_one        <= `FRG_SR1_RESET; // [R19] [R20] [R21]
            invert_protection <= 1'b0; // [R22]
            power_down        <= 1'b0;
            pend_q            <= 8'h00;
            pend_st_q         <= 16'h0000;
            cmd_accepted      <= 1'b0;
            cmd_rejected      <= 1'b0;
            op_aborted        <= ~rst & busy_q;
        end else begin
            op_aborted   <= 1'b0;
            cmd_accepted <= accept;
            cmd_rejected <= new_cmd & ~accept;
            if (in_puw) begin
                puw_q <= puw_q - 32'h1;
            end
            if (in_srst) begin
                srst_q <= srst_q - 32'h1;
                if (srst_q == 32'h1) begin
                    wel_q             <= 1'b0;
                    busy_q            <= 1'b0;
                    locks_q           <= {NLOCK{1'b1}};
                    status_one        <= `FRG_SR1_RESET;
                    invert_protection <= 1'b0;
                    power_down        <= 1'b0;
                end
            end
            if (new_cmd && !in_srst && !hw_reset) begin
                armed_q <= accept & (cmd_byte == `FRG_CMD_RST_EN); // [R24]
            end
            if (rst_pair && accept) begin
                srst_q <= SRST_CYCLES; // [R2]
                op_q   <= 32'h0;
            end else if (accept) begin
                case (cmd_byte)
                    `FRG_CMD_WREN:    wel_q <= 1'b1; // [R11]
                    `FRG_CMD_WRDI:    wel_q <= 1'b0;
                    `FRG_CMD_PDOWN:   power_down <= 1'b1;
                    `FRG_CMD_PDREL:   power_down <= 1'b0;
                    `FRG_CMD_UNLOCK:  locks_q[li] <= 1'b0; // [R15]
                    `FRG_CMD_LOCK:    locks_q[li] <= 1'b1;
                    `FRG_CMD_GUNLOCK: locks_q <= {NLOCK{1'b0}};
                    default: begin
                        if (is_write_cmd(cmd_byte) || cmd_byte == `FRG_CMD_WRSR) begin
                            busy_q    <= 1'b1; // [R18]
                            op_q      <= OP_CYCLES;
                            pend_q    <= cmd_byte;
                            pend_st_q <= wr_status;
                        end
                    end
                endcase
            end
            if (busy_q && op_q != 32'h0) begin
                op_q <= op_q - 32'h1;
                if (op_q == 32'h1) begin
                    busy_q <= 1'b0;
                    wel_q  <= 1'b0; // [R11]
                    if (pend_q == `FRG_CMD_WRSR) begin
                        status_one[`FRG_SR_BP_HI:`FRG_SR_BP_LO] <= pend_st_q[4:2]; // [R19]
                        status_one[`FRG_SR_SRP:`FRG_SR_TB] <= pend_st_q[7:5];
                        invert_protection <= pend_st_q[14]; // [R22]
                    end
                end
            end
            status_one[`FRG_SR_BUSY] <= busy_q;
            status_one[`FRG_SR_WEL]  <= wel_q;
        end
    end
    // ------------------------------------------------------------
    // registered side outputs
    // ------------------------------------------------------------
    always @(posedge clock) begin
        if (rst) begin
            pause_active    <= 1'b0;
            region_locked   <= 1'b1;
            soft_reset_busy <= 1'b0;
        end else begin
            // pause only when shared pin not in reset role
            pause_active    <= ~four_lane_enable_in & ~pause_or_reset_pin_select
                & ~st_q[2] & cs_low; // [R3] [R6]
            region_locked   <= locks_q[li]; // [R13]
            soft_reset_busy <= in_srst;
        end
    end
endmodule // frg_guard
`default_nettype wire

// [design/frg_defines.vh]
// Purpose: constants for the flash reset and write guard
// Assumes: 100 MHz core clock
// Notes:   status bit positions and command codes
`ifndef FRG_DEFINES_VH
`define FRG_DEFINES_VH
`define FRG_CMD_RST_EN      8'h66
`define FRG_CMD_RST         8'h99
`define FRG_CMD_WREN        8'h06
`define FRG_CMD_WRDI        8'h04
`define FRG_CMD_WRSR        8'h01
`define FRG_CMD_RDSR1       8'h05
`define FRG_CMD_PP          8'h02
`define FRG_CMD_QPP         8'h32
`define FRG_CMD_SE          8'h20
`define FRG_CMD_BE32        8'h52
`define FRG_CMD_BE64        8'hd8
`define FRG_CMD_CE          8'hc7
`define FRG_CMD_SUSP        8'h75
`define FRG_CMD_PDOWN       8'hb9
`define FRG_CMD_PDREL       8'hab
`define FRG_CMD_UNLOCK      8'h39
`define FRG_CMD_LOCK        8'h36
`define FRG_CMD_GUNLOCK     8'h98
`define FRG_CMD_SECER       8'h44
`define FRG_CMD_SECPG       8'h42
`define FRG_SR_BUSY         0
`define FRG_SR_WEL          1
`define FRG_SR_BP_LO        2
`define FRG_SR_BP_HI        4
`define FRG_SR_TB           5
`define FRG_SR_SEC          6
`define FRG_SR_SRP          7
`define FRG_SR1_RESET       8'h00
`define FRG_SOFT_RST_NS     30000
`define FRG_HW_RST_NS       1000
`define FRG_PUW_NS          5000000
`define FRG_CLK_MHZ         100
`define FRG_OP_CYCLES       64
`endif

// [dv/frg_guard_props.sv]
// Purpose: port-level checks for frg_guard
// Assumes: command byte held on cmd_byte while its answer pulses
// Notes:   one clock domain, sync reset
`timescale 1ns/1ps
`default_nettype none
module frg_guard_props (
    // clock and reset
    input wire logic       clock,
    input wire logic       rst,
    // inputs
    input wire logic [7:0] cmd_byte,
    input wire logic       dedicated_rst_n,
    input wire logic       status_lockdown,
    input wire logic       protect_scheme_select,
    // outputs
    input wire logic [7:0] status_one,
    input wire logic       cmd_accepted,
    input wire logic       region_locked,
    input wire logic       power_down,
    input wire logic       op_aborted,
    input wire logic       soft_reset_busy
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // depth 2 looks past the answer edge to the state before the take
    a_pin_ignores: assert property (!dedicated_rst_n [*8] |-> !cmd_accepted)
        else $error("command taken under pin reset");
    a_srst_quiet: assert property (soft_reset_busy && $past(soft_reset_busy, 2)
        |-> !cmd_accepted) else $error("command taken in soft reset");
    a_busy_filter: assert property (cmd_accepted && status_one[0]
        && $past(status_one[0], 2) |-> cmd_byte inside {8'h05, 8'h75})
        else $error("command taken while busy");
    a_pdown_filter: assert property (cmd_accepted && $past(power_down, 2)
        |-> cmd_byte == 8'hab) else $error("command taken in power down");
    a_need_latch: assert property (cmd_accepted
        && cmd_byte inside {8'h02, 8'h20, 8'hd8, 8'hc7, 8'h01}
        |-> $past(status_one[1], 2)) else $error("write without latch");
    a_wren_sets: assert property (cmd_accepted && cmd_byte == 8'h06
        |-> ##[0:2] status_one[1]) else $error("latch not set");
    a_done_clears: assert property ($fell(status_one[0]) |-> ##[0:2] !status_one[1])
        else $error("latch left set");
    a_lockdown_wr: assert property (cmd_accepted && cmd_byte == 8'h01
        |-> !status_lockdown) else $error("status write under lockdown");
    a_locked_drop: assert property (cmd_accepted && protect_scheme_select
        && cmd_byte inside {8'h02, 8'h20} |-> !region_locked)
        else $error("locked region written");
    a_abort_clears: assert property (op_aborted |-> ##[0:3] status_one[1:0] == 2'b00)
        else $error("abort left status");
    c_abort: cover property (op_aborted);
    c_srst: cover property ($rose(soft_reset_busy));
    c_done: cover property ($fell(status_one[0]));
endmodule // frg_guard_props
bind frg_guard frg_guard_props u_frg_guard_props (.*);
`default_nettype wire

// [dv/frg_host.sv]
// Purpose: host controller model for the command link
// Assumes: one command per frame, mode 0 link clock
// Notes:   link clock stands still low between frames
`timescale 1ns/1ps
`default_nettype none
module frg_host (
    // clock
    input  wire logic        clock,
    // device answers
    input  wire logic        cmd_accepted,
    input  wire logic        cmd_rejected,
    // serial link
    output var  logic        link_clk,
    output var  logic        cs_n,
    output var  logic        cmd_strobe,
    output var  logic [7:0]  cmd_byte,
    output var  logic [23:0] cmd_addr,
    output var  logic [15:0] wr_status
);
    initial begin
        {link_clk, cs_n, cmd_strobe} = 3'b010;
        cmd_byte = 8'h00;
        cmd_addr = 24'h0;
        wr_status = 16'h0;
    end
    // whole byte per frame, two link periods of 80 ns; r = {accepted, rejected}
    task automatic send(input logic [7:0] c, input logic [23:0] a,
                        input logic [15:0] d, output logic [1:0] r);
        r = 2'b00;
        @(posedge clock);
        {cs_n, cmd_strobe} <= 2'b01;
        cmd_byte <= c;
        cmd_addr <= a;
        wr_status <= d;
        for (int i = 0; i < 24; i++) begin
            @(posedge clock);
            if (i % 4 == 3 && i < 16) link_clk <= ~link_clk;
            r = r | {cmd_accepted, cmd_rejected};
        end
        {cs_n, cmd_strobe} <= 2'b10;
        // released lines show the inverse so stale data never looks live
        cmd_byte <= ~c;
        cmd_addr <= ~a;
        wr_status <= ~d;
        repeat (8) @(posedge clock);
    endtask
endmodule // frg_host
`default_nettype wire

// [dv/frg_guard_bench.sv]
// Purpose: self-checking bench for frg_guard
// Assumes: host model frames each command
// Notes:   powerup and soft reset counts shortened by parameters to keep the run brief; op count raised to 400
`timescale 1ns/1ps
`default_nettype none
module frg_guard_bench;
    localparam int OPC = 400;
    localparam logic [1:0] ACC = 2'b10;
    localparam logic [1:0] REJ = 2'b01;
    logic clock, rst, link_clk, cs_n, cmd_strobe, four_lane_mode, shared_pin_n;
    logic dedicated_rst_n, write_guard_pin, pause_or_reset_pin_select;
    logic four_lane_enable_in, protect_scheme_select, status_lockdown, invert_protection;
    logic cmd_accepted, cmd_rejected, pause_active, op_aborted, region_locked;
    logic power_down, soft_reset_busy, seen_abort;
    logic [7:0]  cmd_byte, status_one;
    logic [23:0] cmd_addr;
    logic [15:0] wr_status;
    logic [1:0]  res;
    int miscompares, tests_run;
    frg_guard #(.PUW_CYCLES(50), .SRST_CYCLES(40), .OP_CYCLES(OPC)) u_frg_guard (.*);
    frg_host u_frg_host (.*);
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) if (op_aborted) seen_abort <= 1'b1;
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c, input logic [15:0] d, input logic [1:0] e);
        u_frg_host.send(c, 24'h0, d, res);
        check({6'h00, res}, {6'h00, e}, "answer");
    endtask
    // enable then status write, then wait out the write
    task automatic wsr(input logic [15:0] d, input logic [1:0] e);
        cmd(8'h06, 16'h0, ACC);
        cmd(8'h01, d, e);
        repeat (OPC + 20) @(posedge clock);
    endtask
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        $display("unexpected at %0t: watchdog", $time);
        give_verdict();
    end
    initial begin
        {rst, shared_pin_n, dedicated_rst_n, write_guard_pin} = 4'hf;
        {four_lane_mode, pause_or_reset_pin_select, four_lane_enable_in} = 3'h0;
        {protect_scheme_select, status_lockdown, seen_abort} = 3'h0;
        miscompares = 0;
        tests_run = 0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        check(status_one, 8'h00, "sr1 default");
        check({7'h00, invert_protection}, 8'h00, "invert");
        check({7'h00, region_locked}, 8'h01, "lock");
        cmd(8'h06, 16'h0, REJ);
        repeat (60) @(posedge clock);
        $display("test powerup done");
        cmd(8'hb9, 16'h0, ACC);
        check({7'h00, power_down}, 8'h01, "power down");
        cmd(8'h06, 16'h0, REJ);
        cmd(8'hab, 16'h0, ACC);
        check({7'h00, power_down}, 8'h00, "released");
        cmd(8'h01, 16'h0, REJ);
        cmd(8'h06, 16'h0, ACC);
        check(status_one, 8'h02, "latch set");
        cmd(8'h04, 16'h0, ACC);
        check(status_one, 8'h00, "latch clear");
        cmd(8'h06, 16'h0, ACC);
        cmd(8'h01, 16'h407c, ACC);
        check({7'h00, status_one[0]}, 8'h01, "busy");
        cmd(8'h06, 16'h0, REJ);
        cmd(8'h05, 16'h0, ACC);
        repeat (OPC) @(posedge clock);
        check(status_one, 8'h7c, "sr1 written");
        check({7'h00, invert_protection}, 8'h01, "invert");
        $display("test latch done");
        wsr(16'h0080, ACC);
        write_guard_pin <= 1'b0;
        wsr(16'h0080, REJ);
        four_lane_mode <= 1'b1;
        wsr(16'h0080, ACC);
        {four_lane_mode, write_guard_pin, status_lockdown} <= 3'b011;
        wsr(16'h0000, REJ);
        status_lockdown <= 1'b0;
        wsr(16'h0000, ACC);
        check(status_one, 8'h00, "guard released");
        $display("test guard done");
        protect_scheme_select <= 1'b1;
        cmd(8'h06, 16'h0, ACC);
        cmd(8'h20, 16'h0, REJ);
        cmd(8'h39, 16'h0, ACC);
        cmd(8'h06, 16'h0, ACC);
        cmd(8'h20, 16'h0, ACC);
        repeat (OPC + 20) @(posedge clock);
        protect_scheme_select <= 1'b0;
        $display("test locks done");
        cmd(8'h66, 16'h0, ACC);
        cmd(8'h05, 16'h0, ACC);
        u_frg_host.send(8'h99, 24'h0, 16'h0, res);
        check({7'h00, soft_reset_busy}, 8'h00, "no soft reset");
        for (int m = 0; m < 2; m++) begin
            four_lane_mode <= m[0];
            cmd(8'h66, 16'h0, ACC);
            cmd(8'h99, 16'h0, ACC);
            check({7'h00, soft_reset_busy}, 8'h01, "soft reset");
            cmd(8'h05, 16'h0, REJ);
            repeat (60) @(posedge clock);
            check(status_one, 8'h00, "sr1 after reset");
            check({7'h00, region_locked}, 8'h01, "relocked");
        end
        four_lane_mode <= 1'b0;
        $display("test soft reset done");
        shared_pin_n <= 1'b0;
        check({7'h00, pause_active}, 8'h00, "no pause");
        fork
            u_frg_host.send(8'h05, 24'h0, 16'h0, res);
            begin
                repeat (12) @(posedge clock);
                check({7'h00, pause_active}, 8'h01, "pause");
            end
        join
        shared_pin_n <= 1'b1;
        $display("test pause done");
        // case 0 dedicated pin, 1 shared as reset, 2 shared with four lanes
        for (int k = 0; k < 3; k++) begin
            pause_or_reset_pin_select <= (k != 0);
            four_lane_enable_in <= (k != 1);
            cmd(8'h06, 16'h0, ACC);
            if (k == 0) cmd(8'hc7, 16'h0, ACC);
            if (k == 0) dedicated_rst_n <= 1'b0;
            else shared_pin_n <= 1'b0;
            if (k == 0) u_frg_host.send(8'h05, 24'h0, 16'h0, res);
            if (k == 0) check({7'h00, res == ACC}, 8'h00, "pin low cmd");
            repeat (120) @(posedge clock);
            {dedicated_rst_n, shared_pin_n} <= 2'b11;
            repeat (70) @(posedge clock);
            check(status_one, (k == 2) ? 8'h02 : 8'h00, "pin reset");
        end
        check({7'h00, seen_abort}, 8'h01, "abort");
        $display("test pins done");
        give_verdict();
    end
endmodule // frg_guard_bench
`default_nettype wire
